// ===== core/sfc_cfg.svh
// offsets, field positions, reset values and counts of the flag unit
// assumes inclusion by bare name from the package, the checker and the bench
`ifndef SFC_CFG_SVH
`define SFC_CFG_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define SFC_OFS_STATUS   12'h000
`define SFC_OFS_INSTR    12'h004
`define SFC_OFS_STATE    12'h008
`define SFC_OFS_CFG      12'h00C

// ---------------------------------------------------------------
// status register bit positions
// ---------------------------------------------------------------
`define SFC_FLG_C        0
`define SFC_FLG_Z        1
`define SFC_FLG_N        2
`define SFC_FLG_V        3
`define SFC_FLG_S        4
`define SFC_FLG_H        5
`define SFC_FLG_T        6
`define SFC_FLG_I        7

// ---------------------------------------------------------------
// instruction register fields
// ---------------------------------------------------------------
`define SFC_INS_OP_LSB   0
`define SFC_INS_OP_MSB   3
`define SFC_INS_INT_BIT  8
`define SFC_INS_EXT_BIT  9
`define SFC_INS_BASE_LSB 10
`define SFC_INS_BASE_MSB 11

// ---------------------------------------------------------------
// state and config register fields
// ---------------------------------------------------------------
`define SFC_ST_BUSY_BIT  0
`define SFC_ST_SLP_BIT   1
`define SFC_ST_CYC_LSB   8
`define SFC_ST_CYC_MSB   12
`define SFC_CFG_EW_LSB   0
`define SFC_CFG_EW_MSB   3

// ---------------------------------------------------------------
// reset values and counts
// ---------------------------------------------------------------
`define SFC_RST_FLAGS    8'h00
`define SFC_RST_EXTWAIT  4'h0
`define SFC_INSTR_CYC    5'h01
`define SFC_INTSRAM_XTRA 5'h01

`endif

// ===== core/sfc_pkg.sv
// types shared by the flag unit core and its cycle timer
// assumes the config header sits in the include path
`include "sfc_cfg.svh"

package sfc_pkg;

  // -------------------------------------------------------------
  // instruction codes
  // -------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NOP     = 4'h0,
    OP_SET_S   = 4'h1,
    OP_CLR_S   = 4'h2,
    OP_SET_V   = 4'h3,
    OP_CLR_V   = 4'h4,
    OP_SET_H   = 4'h5,
    OP_CLR_H   = 4'h6,
    OP_IRQ_EN  = 4'h7,
    OP_IRQ_DIS = 4'h8,
    OP_SET_T   = 4'h9,
    OP_CLR_T   = 4'hA,
    OP_BRK     = 4'hB,
    OP_SLP     = 4'hC,
    OP_WDT     = 4'hD,
    OP_MEM     = 4'hE
  } sfc_op_t;

  // -------------------------------------------------------------
  // execution states
  // -------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_MEM
  } sfc_state_t;

  typedef logic [4:0] sfc_cyc_t;

endpackage

// ===== core/sfc_mem_timer.sv
// down counter that stretches a data memory access
// assumes load only while the core sits idle or in execute
`timescale 1ns/100ps

module sfc_mem_timer
  import sfc_pkg::*;
(
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          ce,
  // control
  input  wire logic          load,
  input  wire sfc_pkg::sfc_cyc_t load_val,
  // status
  output logic               last
);

  sfc_cyc_t remain_reg;
  sfc_cyc_t remain_next;

  // ---------------------------------------------------------------
  // next count
  // ---------------------------------------------------------------
  always_comb begin
    remain_next = remain_reg;
    if (load) begin
      remain_next = load_val;
    end else if (remain_reg != 5'h00) begin
      remain_next = remain_reg - 5'h01;
    end
  end

  // ---------------------------------------------------------------
  // count register, frozen with ce low
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remain_reg <= 5'h00;
    end else if (ce) begin
      remain_reg <= remain_next;
    end
  end

  // final wait cycle of the access
  assign last = (remain_reg == 5'h01);

endmodule // sfc_mem_timer

// ===== core/sfc_core.sv
// flag set/clear and processor control execution unit, apb slave
// assumes apb master on pclk; sleep, watchdog and debug outside
//
// Behaviour
// RULE_01 - signed flag set/clear, one cycle
// RULE_02 - overflow flag set/clear, others untouched
// RULE_03 - half carry set/clear, exactly one cycle
// RULE_04 - break: one cycle, flags unchanged
// RULE_05 - sleep: one cycle, then enter sleep
// RULE_06 - watchdog restart: one cycle, restart pulse
// RULE_07 - external memory access may exceed listed count
// RULE_08 - internal sram access adds one cycle
// RULE_09 - global interrupt enable/disable, one cycle
// RULE_10 - transfer bit set/clear; nop does nothing
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/100ps

module sfc_core
  import sfc_pkg::*;
(
  // clock, reset, enable
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          ce,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // system side
  input  wire logic          wake_event,
  output logic [7:0]         status_register,
  output logic               busy,
  output logic               sleep_active,
  output logic               wdt_restart,
  output logic               brk_pulse
);

  import sfc_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  sfc_state_t  state_reg,   state_next;
  sfc_op_t     op_reg,      op_next;
  logic        int_reg,     int_next;
  logic        ext_reg,     ext_next;
  logic [1:0]  base_reg,    base_next;
  logic [3:0]  extw_reg,    extw_next;
  logic [7:0]  flags_reg,   flags_next;
  logic        slp_reg,     slp_next;
  logic        wdt_reg,     wdt_next;
  logic        brk_reg,     brk_next;
  sfc_cyc_t    cyc_reg,     cyc_next;
  logic [31:0] rdata_reg,   rdata_next;

  logic        acc;
  logic        wr;
  logic        hit_status;
  logic        hit_instr;
  logic        hit_state;
  logic        hit_cfg;
  logic        mapped;
  logic        instr_ok;
  logic        tmr_load;
  logic        tmr_last;
  sfc_cyc_t    mem_total;
  sfc_cyc_t    base_cyc;

  // ---------------------------------------------------------------
  // apb decode; zero wait states, ce low stalls the bus
  // ---------------------------------------------------------------
  assign acc        = psel & penable & ce;
  assign wr         = acc & pwrite;
  assign hit_status = (paddr == `SFC_OFS_STATUS);
  assign hit_instr  = (paddr == `SFC_OFS_INSTR);
  assign hit_state  = (paddr == `SFC_OFS_STATE);
  assign hit_cfg    = (paddr == `SFC_OFS_CFG);
  assign mapped     = hit_status | hit_instr | hit_state | hit_cfg;
  // new instructions refused while one runs or the core sleeps
  assign instr_ok   = (state_reg == ST_IDLE) & ~slp_reg;
  assign pready     = ce;
  assign pslverr    = psel & penable &
                      (~mapped | (pwrite & hit_instr & ~instr_ok));

  // ---------------------------------------------------------------
  // memory access length: tabulated count plus penalties
  // ---------------------------------------------------------------
  always_comb begin
    base_cyc = (base_reg == 2'b00) ? `SFC_INSTR_CYC : {3'b000, base_reg};
    if (ext_reg) begin
      mem_total = base_cyc + {1'b0, extw_reg};  // RULE_07
    end else if (int_reg) begin
      mem_total = base_cyc + `SFC_INTSRAM_XTRA;  // RULE_08
    end else begin
      mem_total = base_cyc;
    end
  end

  // extra cycles after the execute cycle
  assign tmr_load = (state_reg == ST_EXEC) & (op_reg == OP_MEM) &
                    (mem_total > `SFC_INSTR_CYC);

  sfc_mem_timer u_timer (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .load     (tmr_load),
    .load_val (mem_total - `SFC_INSTR_CYC),
    .last     (tmr_last)
  );

  // ---------------------------------------------------------------
  // sequencer and instruction latch
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    op_next    = op_reg;
    int_next   = int_reg;
    ext_next   = ext_reg;
    base_next  = base_reg;
    cyc_next   = cyc_reg;
    case (state_reg)
      ST_IDLE: begin
        if (wr & hit_instr & instr_ok) begin
          op_next    = sfc_op_t'(pwdata[`SFC_INS_OP_MSB:`SFC_INS_OP_LSB]);
          int_next   = pwdata[`SFC_INS_INT_BIT];
          ext_next   = pwdata[`SFC_INS_EXT_BIT];
          base_next  = pwdata[`SFC_INS_BASE_MSB:`SFC_INS_BASE_LSB];
          state_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (tmr_load) begin
          cyc_next   = mem_total;
          state_next = ST_MEM;
        end else begin
          cyc_next   = `SFC_INSTR_CYC;  // RULE_04 RULE_05 RULE_06
          state_next = ST_IDLE;
        end
      end
      ST_MEM: begin
        if (tmr_last) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // flag updates and control pulses; instruction beats software
  // ---------------------------------------------------------------
  always_comb begin
    flags_next = flags_reg;
    wdt_next   = 1'b0;
    brk_next   = 1'b0;
    // wake clears sleep, but entering sleep in the same cycle wins
    slp_next   = slp_reg & ~wake_event;
    if (wr & hit_status) begin
      flags_next = pwdata[7:0];
    end
    if (state_reg == ST_EXEC) begin
      case (op_reg)
        OP_SET_S:   flags_next[`SFC_FLG_S] = 1'b1;  // RULE_01
        OP_CLR_S:   flags_next[`SFC_FLG_S] = 1'b0;  // RULE_01
        OP_SET_V:   flags_next[`SFC_FLG_V] = 1'b1;  // RULE_02
        OP_CLR_V:   flags_next[`SFC_FLG_V] = 1'b0;  // RULE_02
        OP_SET_H:   flags_next[`SFC_FLG_H] = 1'b1;  // RULE_03
        OP_CLR_H:   flags_next[`SFC_FLG_H] = 1'b0;  // RULE_03
        OP_IRQ_EN:  flags_next[`SFC_FLG_I] = 1'b1;  // RULE_09
        OP_IRQ_DIS: flags_next[`SFC_FLG_I] = 1'b0;  // RULE_09
        OP_SET_T:   flags_next[`SFC_FLG_T] = 1'b1;  // RULE_10
        OP_CLR_T:   flags_next[`SFC_FLG_T] = 1'b0;  // RULE_10
        OP_BRK:     brk_next = 1'b1;  // RULE_04
        OP_SLP:     slp_next = 1'b1;  // RULE_05
        OP_WDT:     wdt_next = 1'b1;  // RULE_06
        // nop and memory access keep a concurrent software write
        default:    ;  // RULE_10
      endcase
    end
  end

  // ---------------------------------------------------------------
  // register config written in the access phase, read data sampled in the setup phase
  // ---------------------------------------------------------------
  always_comb begin
    extw_next  = extw_reg;
    rdata_next = rdata_reg;
    if (wr & hit_cfg) begin
      extw_next = pwdata[`SFC_CFG_EW_MSB:`SFC_CFG_EW_LSB];
    end
    if (psel & ~penable) begin
      rdata_next = 32'h0000_0000;
      if (paddr == `SFC_OFS_STATUS) begin
        rdata_next[7:0] = flags_reg;
      end else if (paddr == `SFC_OFS_INSTR) begin
        rdata_next[`SFC_INS_OP_MSB:`SFC_INS_OP_LSB] = op_reg;
        rdata_next[`SFC_INS_INT_BIT] = int_reg;
        rdata_next[`SFC_INS_EXT_BIT] = ext_reg;
        rdata_next[`SFC_INS_BASE_MSB:`SFC_INS_BASE_LSB] = base_reg;
      end else if (paddr == `SFC_OFS_STATE) begin
        rdata_next[`SFC_ST_BUSY_BIT] = (state_reg != ST_IDLE);
        rdata_next[`SFC_ST_SLP_BIT]  = slp_reg;
        rdata_next[`SFC_ST_CYC_MSB:`SFC_ST_CYC_LSB] = cyc_reg;
      end else if (paddr == `SFC_OFS_CFG) begin
        rdata_next[`SFC_CFG_EW_MSB:`SFC_CFG_EW_LSB] = extw_reg;
      end
    end
  end

  // ---------------------------------------------------------------
  // all state registers, frozen while ce is low
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      op_reg    <= OP_NOP;
      int_reg   <= 1'b0;
      ext_reg   <= 1'b0;
      base_reg  <= 2'b00;
      extw_reg  <= `SFC_RST_EXTWAIT;
      flags_reg <= `SFC_RST_FLAGS;
      slp_reg   <= 1'b0;
      wdt_reg   <= 1'b0;
      brk_reg   <= 1'b0;
      cyc_reg   <= 5'h00;
      rdata_reg <= 32'h0000_0000;
    end else if (ce) begin
      state_reg <= state_next;
      op_reg    <= op_next;
      int_reg   <= int_next;
      ext_reg   <= ext_next;
      base_reg  <= base_next;
      extw_reg  <= extw_next;
      flags_reg <= flags_next;
      slp_reg   <= slp_next;
      wdt_reg   <= wdt_next;
      brk_reg   <= brk_next;
      cyc_reg   <= cyc_next;
      rdata_reg <= rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata          = rdata_reg;
  assign status_register = flags_reg;
  assign busy            = (state_reg != ST_IDLE);
  assign sleep_active    = slp_reg;
  assign wdt_restart     = wdt_reg;
  assign brk_pulse       = brk_reg;

endmodule // sfc_core

// ===== bench/sfc_core_asserts.sv
// checker for the flag and control unit, bound to sfc_core
// assumes the cfg header on the include path and ce high while executing
`timescale 1ns/100ps
`include "sfc_cfg.svh"

module sfc_core_asserts (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // system side
  input wire logic        wake_event,
  input wire logic [7:0]  status_register,
  input wire logic        busy,
  input wire logic        sleep_active,
  input wire logic        wdt_restart,
  input wire logic        brk_pulse
);
  logic       acc, wr_ins, set_reg;
  logic [3:0] op, ew_reg;
  logic [4:0] n_next, n_reg, cnt_reg;
  logic [7:0] msk, msk_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------
  // helper: accepted instruction, flag mask, expected length
  // ----------------------------------------
  assign acc    = psel && penable && pwrite && ce;
  assign wr_ins = acc && paddr == `SFC_OFS_INSTR && !busy && !sleep_active;
  assign op     = pwdata[3:0];

  always_comb begin
    case (op)
      4'h1, 4'h2: msk = 8'hEF;
      4'h3, 4'h4: msk = 8'hF7;
      4'h5, 4'h6: msk = 8'hDF;
      4'h7, 4'h8: msk = 8'h7F;
      4'h9, 4'hA: msk = 8'hBF;
      default:    msk = 8'hFF;
    endcase
    n_next = (pwdata[11:10] == 2'h0) ? 5'h01 : {3'h0, pwdata[11:10]};
    if (op != 4'hE) n_next = `SFC_INSTR_CYC;
    else if (pwdata[9]) n_next = n_next + {1'b0, ew_reg};
    else if (pwdata[8]) n_next = n_next + `SFC_INTSRAM_XTRA;
  end

  // cfg mirror so external waits are known without peeking inside
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msk_reg <= 8'hFF;
      set_reg <= 1'b0;
      ew_reg  <= 4'h0;
      n_reg   <= 5'h00;
      cnt_reg <= 5'h00;
    end else begin
      if (acc && paddr == `SFC_OFS_CFG) ew_reg <= pwdata[3:0];
      if (wr_ins) begin
        msk_reg <= msk;
        set_reg <= op[0];
        n_reg   <= n_next;
        cnt_reg <= 5'h00;
      end else if (busy && ce) begin
        cnt_reg <= cnt_reg + 5'h01;
      end
    end
  end

  property p_flag_val;
    wr_ins && msk != 8'hFF |-> ##2
      (status_register & ~msk_reg) == (set_reg ? ~msk_reg : 8'h00);
  endproperty
  a_flag_val: assert property (p_flag_val)
    else $error("flag not forced by instruction");

  property p_others;
    wr_ins |=> ##1
      (((status_register ^ $past(status_register)) & msk_reg) == 8'h00);
  endproperty
  a_others: assert property (p_others)
    else $error("unrelated flag changed");

  property p_one_cyc;
    wr_ins && op != 4'hE |=> busy ##1 !busy;
  endproperty
  a_one_cyc: assert property (p_one_cyc)
    else $error("instruction not one cycle");

  property p_wdt;
    wr_ins && op == 4'hD |=> !wdt_restart ##1 wdt_restart ##1 !wdt_restart;
  endproperty
  a_wdt: assert property (p_wdt)
    else $error("watchdog restart pulse wrong");

  property p_brk;
    wr_ins && op == 4'hB |=> !brk_pulse ##1 brk_pulse ##1 !brk_pulse;
  endproperty
  a_brk: assert property (p_brk)
    else $error("break pulse wrong");

  property p_sleep;
    wr_ins && op == 4'hC |-> ##2 sleep_active;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep not entered");

  property p_wake;
    sleep_active && wake_event && ce && !busy |=> !sleep_active;
  endproperty
  a_wake: assert property (p_wake)
    else $error("sleep not left on wake");

  property p_mem;
    $fell(busy) |-> cnt_reg == n_reg;
  endproperty
  a_mem: assert property (p_mem)
    else $error("busy length differs from expected");
endmodule // sfc_core_asserts

bind sfc_core sfc_core_asserts u_sfc_core_asserts (
  .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
  .wake_event, .status_register, .busy, .sleep_active, .wdt_restart,
  .brk_pulse
);

// ===== bench/sfc_core_tb.sv
// self-checking bench for the flag and control unit
// assumes sfc_core with its checker bound; apb driven here
`timescale 1ns/100ps
`include "sfc_cfg.svh"

module sfc_core_tb;
  logic        pclk, presetn, ce, psel, penable, pwrite, wake_event;
  logic        pready, pslverr, busy, sleep_active, wdt_restart, brk_pulse;
  logic        resp_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, r;
  logic [7:0]  status_register, sr;
  logic [31:0] seed = 32'hB54E00C6;
  int          errors, check_count, n, wdt_n, brk_n;

  sfc_core u_sfc_core (
    .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .wake_event, .status_register, .busy,
    .sleep_active, .wdt_restart, .brk_pulse
  );

  // ----------------------------------------
  // clock, pulse counters, helpers
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (wdt_restart === 1'b1) wdt_n++;
    if (brk_pulse === 1'b1) brk_n++;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [7:0] exp_sr(input logic [7:0] s,
                                        input logic [3:0] o);
    case (o)
      4'h1, 4'h2: s[`SFC_FLG_S] = o[0];
      4'h3, 4'h4: s[`SFC_FLG_V] = o[0];
      4'h5, 4'h6: s[`SFC_FLG_H] = o[0];
      4'h7, 4'h8: s[`SFC_FLG_I] = o[0];
      4'h9, 4'hA: s[`SFC_FLG_T] = o[0];
      default: ;
    endcase
    return s;
  endfunction

  function automatic int mem_n(input logic [31:0] q);
    mem_n = (q[11:10] == 2'h0) ? 1 : int'(q[11:10]);
    if (q[9]) mem_n += int'(q[3:0]);
    else if (q[8]) mem_n++;
  endfunction

  task automatic chk(input logic [31:0] got, exp, input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // one apb transfer; waits for pready, no assumed latency
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd       = prdata;
    resp_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // counts busy cycles over a window longer than any instruction
  task automatic run(output int c);
    c = 0;
    repeat (40) begin
      @(posedge pclk);
      if (busy === 1'b1) c++;
    end
  endtask

  task automatic stop_test();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    stop_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    wake_event = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk(32'(status_register), 32'(`SFC_RST_FLAGS), "reset flags");
    // every one-cycle opcode except sleep over random flag contents
    for (int o = 0; o < 16; o++) begin
      if (o == 12 || o == 14) continue;
      r = rnd();
      sr = r[7:0];
      apb(1'b1, `SFC_OFS_STATUS, {24'h0, sr});
      apb(1'b1, `SFC_OFS_INSTR, 32'(o));
      chk(32'(resp_err), 32'h0, "instr accepted");
      run(n);
      chk(32'(status_register), 32'(exp_sr(sr, o[3:0])), "flags");
      chk(32'(n), 32'h1, "op cycles");
      apb(1'b0, `SFC_OFS_STATUS, 32'h0);
      chk(rd, 32'(exp_sr(sr, o[3:0])), "status read");
    end
    chk(32'(wdt_n), 32'h1, "watchdog pulses");
    chk(32'(brk_n), 32'h1, "break pulses");
    // sleep, refused instruction, wake
    apb(1'b1, `SFC_OFS_INSTR, 32'h0000000C);
    run(n);
    chk(32'(sleep_active), 32'h1, "sleeping");
    apb(1'b1, `SFC_OFS_INSTR, 32'h00000001);
    chk(32'(resp_err), 32'h1, "instr while asleep");
    wake_event <= 1'b1;
    @(posedge pclk);
    wake_event <= 1'b0;
    @(posedge pclk);
    chk(32'(sleep_active), 32'h0, "woken");
    // memory access lengths, corners first
    for (int i = 0; i < 12; i++) begin
      r = rnd();
      if (i == 0) r[11:8] = 4'h1;
      if (i == 1) r[11:0] = 12'hF0F;
      apb(1'b1, `SFC_OFS_CFG, {28'h0, r[3:0]});
      apb(1'b1, `SFC_OFS_INSTR, {20'h0, r[11:8], 8'h0E});
      run(n);
      chk(32'(n), 32'(mem_n(r)), "mem cycles");
      apb(1'b0, `SFC_OFS_STATE, 32'h0);
      chk({27'h0, rd[12:8]}, 32'(mem_n(r)), "state cycles");
      apb(1'b0, `SFC_OFS_INSTR, 32'h0);
      chk(rd, {20'h0, r[11:8], 8'h0E}, "instr readback");
    end
    // instruction while busy is refused
    apb(1'b1, `SFC_OFS_CFG, 32'h0000000F);
    apb(1'b1, `SFC_OFS_INSTR, 32'h0000020E);
    apb(1'b1, `SFC_OFS_INSTR, 32'h00000001);
    chk(32'(resp_err), 32'h1, "instr while busy");
    run(n);
    apb(1'b0, 12'h010, 32'h0);
    chk(32'(resp_err), 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    // stall the access phase with ce low
    fork
      begin
        repeat (2) @(posedge pclk);
        ce <= 1'b0;
        repeat (3) @(posedge pclk);
        ce <= 1'b1;
      end
    join_none
    apb(1'b0, `SFC_OFS_CFG, 32'h0);
    chk(rd, 32'h0000000F, "stalled read");
    stop_test();
  end
endmodule // sfc_core_tb
